// *** hw/hrc_ctrl.sv ***
// host controller that unlocks and transfers the hidden clock image
`timescale 1ns/1ps
`default_nettype none
`include "hrc_cfg.svh"
// Function
// - host releases chip select one clock after power fail is seen.
// - one read with select and output enable opens an attempt.
// - all key writes go to one scratch address.
// - key is sent least significant bit first, one per write.
// - host moves registers only as whole 8-bit groups.
// - transfer runs register 0 bit 0 to register 7 bit 7.

module hrc_ctrl
(
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rstn_i,
    // command port
    input  wire logic [3:0]  addr_i,
    input  wire logic [31:0] wdata_i,
    input  wire logic        wr_i,
    input  wire logic        rd_i,
    output logic      [31:0] rdata_o,
    // supply monitor
    input  wire logic        power_ok_i,
    // device pins
    output logic      [18:0] mem_addr_o,
    output logic             mem_ce_n_o,
    output logic             mem_oe_n_o,
    output logic             mem_we_n_o,
    output logic             dq0_o,
    output logic             dq0_oe_n_o,
    input  wire logic        dq0_i,
    output logic             abort_n_o
);

    typedef struct packed {
        hrc_pkg::hrc_state_t          st;
        hrc_pkg::hrc_phase_t          ph;
        logic [1:0]                   tmr;
        logic [6:0]                   idx;
        logic                         write;
        logic                         busy;
        logic                         done;
        logic                         abrt;
        logic [`HRC_KEY_BITS-1:0]     key;
        logic [63:0]                  wimg;
        logic [63:0]                  rimg;
        logic [18:0]                  scratch;
        logic [31:0]                  rdata;
        logic                         ce_n;
        logic                         oe_n;
        logic                         we_n;
        logic                         dq;
        logic                         dq_oe_n;
    } hrc_regs_t;

    hrc_regs_t r;
    hrc_regs_t next_r;

    // index is 7 bits wide for the end test; only 6 bits address the image
    function automatic logic bit_at(input logic [63:0] v, input logic [6:0] i);
        bit_at = v[i[5:0]];
    endfunction

    // ---------------------------------------------------------------
    // sequencer
    // ---------------------------------------------------------------
    always_comb
    begin
        next_r = r;
        next_r.abrt = 1'b0;
        if (wr_i)
        begin
            unique case (addr_i)
                `HRC_OFS_CTRL:
                begin
                    // a start while busy is ignored
                    if (wdata_i[`HRC_CTRL_GO] && !r.busy && power_ok_i)
                    begin
                        next_r.busy  = 1'b1;
                        next_r.done  = 1'b0;
                        next_r.write = wdata_i[`HRC_CTRL_WRITE];
                        next_r.st    = hrc_pkg::HRC_SETUP;
                        next_r.ph    = hrc_pkg::HRC_PH_OPEN;
                        next_r.idx   = 7'h00;
                        next_r.tmr   = 2'h0;
                    end
                    next_r.abrt = wdata_i[`HRC_CTRL_ABORT];
                end
                `HRC_OFS_KEY_LO:   next_r.key[31:0]  = wdata_i;
                `HRC_OFS_KEY_HI:   next_r.key[63:32] = wdata_i;
                `HRC_OFS_WDATA_LO: next_r.wimg[31:0]  = wdata_i;
                `HRC_OFS_WDATA_HI: next_r.wimg[63:32] = wdata_i;
                `HRC_OFS_SCRATCH:  next_r.scratch    = wdata_i[18:0];
                default:           next_r.rdata      = r.rdata;
            endcase
        end
        if (rd_i)
        begin
            unique case (addr_i)
                `HRC_OFS_CTRL:     next_r.rdata = {29'h0, r.abrt, r.write, r.busy};
                `HRC_OFS_STATUS:   next_r.rdata = {25'h0, r.idx};
                `HRC_OFS_KEY_LO:   next_r.rdata = r.key[31:0];
                `HRC_OFS_KEY_HI:   next_r.rdata = r.key[63:32];
                `HRC_OFS_WDATA_LO: next_r.rdata = r.wimg[31:0];
                `HRC_OFS_WDATA_HI: next_r.rdata = r.wimg[63:32];
                `HRC_OFS_RDATA_LO: next_r.rdata = r.rimg[31:0];
                `HRC_OFS_RDATA_HI: next_r.rdata = r.rimg[63:32];
                `HRC_OFS_SCRATCH:  next_r.rdata = {13'h0, r.scratch};
                default:           next_r.rdata = 32'h0;
            endcase
            // status bit 31 is done flag, shown on status read
            if (addr_i == `HRC_OFS_STATUS)
                next_r.rdata[31] = r.done;
        end

        // supply loss: release select at once, drop the transfer
        if (!power_ok_i && r.busy)
        begin
            next_r.st      = hrc_pkg::HRC_IDLE;
            next_r.busy    = 1'b0;
            next_r.ce_n    = 1'b1;
            next_r.oe_n    = 1'b1;
            next_r.we_n    = 1'b1;
            next_r.dq_oe_n = 1'b1;
        end
        else
        begin
            unique case (r.st)
                hrc_pkg::HRC_IDLE:
                begin
                    next_r.ce_n    = 1'b1;
                    next_r.dq_oe_n = 1'b1;
                end
                hrc_pkg::HRC_SETUP:
                begin
                    next_r.ce_n = 1'b0;
                    // open read, key writes, then data direction
                    if (r.ph == hrc_pkg::HRC_PH_OPEN)
                    begin
                        next_r.oe_n    = 1'b0;
                        next_r.dq_oe_n = 1'b1;
                    end
                    else if (r.ph == hrc_pkg::HRC_PH_KEY)
                    begin
                        next_r.we_n    = 1'b0;
                        next_r.dq      = bit_at(r.key, r.idx);
                        next_r.dq_oe_n = 1'b0;
                    end
                    else if (r.write)
                    begin
                        next_r.we_n    = 1'b0;
                        next_r.dq      = bit_at(r.wimg, r.idx);
                        next_r.dq_oe_n = 1'b0;
                    end
                    else
                    begin
                        next_r.oe_n    = 1'b0;
                        next_r.dq_oe_n = 1'b1;
                    end
                    next_r.tmr = 2'h0;
                    next_r.st  = hrc_pkg::HRC_STROBE;
                end
                hrc_pkg::HRC_STROBE:
                begin
                    next_r.tmr = r.tmr + 2'h1;
                    if (32'(r.tmr) + 1 >= `HRC_PHASE_CYC)
                    begin
                        if (r.ph == hrc_pkg::HRC_PH_XFER && !r.write)
                            next_r.rimg[r.idx[5:0]] = dq0_i;
                        next_r.ce_n = 1'b1;
                        next_r.oe_n = 1'b1;
                        next_r.we_n = 1'b1;
                        next_r.st   = hrc_pkg::HRC_RECOVER;
                    end
                end
                hrc_pkg::HRC_RECOVER:
                begin
                    // data released a clock after the strobe: hold time on the far side
                    next_r.dq_oe_n = 1'b1;
                    next_r.st      = hrc_pkg::HRC_SETUP;
                    if (r.ph == hrc_pkg::HRC_PH_OPEN)
                    begin
                        next_r.ph  = hrc_pkg::HRC_PH_KEY;
                        next_r.idx = 7'h00;
                    end
                    else if (r.idx == 7'd63)
                    begin
                        next_r.idx = 7'h00;
                        if (r.ph == hrc_pkg::HRC_PH_KEY)
                            next_r.ph = hrc_pkg::HRC_PH_XFER;
                        else
                            next_r.st = hrc_pkg::HRC_DONE;
                    end
                    else
                        next_r.idx = r.idx + 7'h01;
                end
                hrc_pkg::HRC_DONE:
                begin
                    next_r.busy = 1'b0;
                    next_r.done = 1'b1;
                    next_r.st   = hrc_pkg::HRC_IDLE;
                end
                default:
                    next_r.st = hrc_pkg::HRC_IDLE;
            endcase
        end
    end

    // reset leaves every strobe inactive so the device sees no stray cycle
    always_ff @(posedge clk_i or negedge rstn_i)
    begin
        if (!rstn_i)
        begin
            r         <= '0;
            r.st      <= hrc_pkg::HRC_IDLE;
            r.ph      <= hrc_pkg::HRC_PH_OPEN;
            r.key     <= `HRC_KEY_RST;
            r.scratch <= `HRC_SCRATCH_RST;
            r.ce_n    <= 1'b1;
            r.oe_n    <= 1'b1;
            r.we_n    <= 1'b1;
            r.dq_oe_n <= 1'b1;
        end
        else
            r <= next_r;
    end

    // ---------------------------------------------------------------
    // outputs
    // ---------------------------------------------------------------
    assign rdata_o    = r.rdata;
    assign mem_addr_o = r.scratch;
    assign mem_ce_n_o = r.ce_n;
    assign mem_oe_n_o = r.oe_n;
    assign mem_we_n_o = r.we_n;
    assign dq0_o      = r.dq;
    assign dq0_oe_n_o = r.dq_oe_n;
    // abort pulse only acts when the day register allows it
    assign abort_n_o  = ~r.abrt;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);

    a_fail_release: assert property (!power_ok_i |=> r.ce_n)
        else $error("select held during power fail");
    a_no_read_write: assert property (!(!r.oe_n && !r.we_n))
        else $error("read and write strobes together");
    a_key_drive: assert property (!r.we_n |-> !r.dq_oe_n)
        else $error("write strobe without data drive");
    a_key_bit: assert property ((!r.we_n && r.ph == hrc_pkg::HRC_PH_KEY)
        |-> r.dq == r.key[r.idx[5:0]])
        else $error("key bit out of order");
    a_open_read: assert property ((r.st == hrc_pkg::HRC_SETUP && $past(!r.busy))
        |=> !r.oe_n)
        else $error("attempt not opened by read");
    a_same_addr: assert property (!r.ce_n |-> $stable(mem_addr_o))
        else $error("address moved in cycle");
    a_read_drive: assert property (!r.oe_n |-> r.dq_oe_n)
        else $error("driving bus while reading");
    a_end_idle: assert property (r.st == hrc_pkg::HRC_DONE |=> r.ce_n && !r.busy)
        else $error("select left active after transfer");
    a_strobe_len: assert property (($fell(r.ce_n) && power_ok_i)
        |=> !r.ce_n ##1 r.ce_n)
        else $error("select width not two clocks");
    a_key_start: assert property ((r.ph == hrc_pkg::HRC_PH_KEY
        && $past(r.ph) == hrc_pkg::HRC_PH_OPEN) |-> r.idx == 7'h00)
        else $error("key not started at its first bit");
    a_fail_drop: assert property ((!power_ok_i && r.busy) |=> !r.busy)
        else $error("transfer kept through power fail");

    // ---------------------------------------------------------------
    // scenario covers
    // ---------------------------------------------------------------
    c_go: cover property (r.st == hrc_pkg::HRC_SETUP && r.ph == hrc_pkg::HRC_PH_XFER);
    c_key: cover property (r.ph == hrc_pkg::HRC_PH_KEY && !r.we_n);
    c_done: cover property (r.done && !r.write);
    c_wdone: cover property (r.done && r.write);
    c_fail: cover property (r.busy && !power_ok_i);

endmodule // hrc_ctrl
`default_nettype wire

// *** pkg/hrc_cfg.svh ***
// constants for the hidden clock access controller
`ifndef HRC_CFG_SVH
`define HRC_CFG_SVH

// ---------------------------------------------------------------
// command port register map
// ---------------------------------------------------------------
`define HRC_OFS_CTRL     4'h0
`define HRC_OFS_STATUS   4'h1
`define HRC_OFS_KEY_LO   4'h2
`define HRC_OFS_KEY_HI   4'h3
`define HRC_OFS_WDATA_LO 4'h4
`define HRC_OFS_WDATA_HI 4'h5
`define HRC_OFS_RDATA_LO 4'h6
`define HRC_OFS_RDATA_HI 4'h7
`define HRC_OFS_SCRATCH  4'h8

// ---------------------------------------------------------------
// control fields
// ---------------------------------------------------------------
`define HRC_CTRL_GO      0
`define HRC_CTRL_WRITE   1
`define HRC_CTRL_ABORT   2

// ---------------------------------------------------------------
// clock image layout
// ---------------------------------------------------------------
`define HRC_REG_BITS     8
`define HRC_REG_COUNT    8
`define HRC_KEY_BITS     64
`define HRC_DAY_REG      4
`define HRC_DAY_RST_BIT  4
`define HRC_DAY_OSC_BIT  5
`define HRC_HOUR_REG     3
`define HRC_HOUR_12_BIT  7
`define HRC_HOUR_PM_BIT  5

// ---------------------------------------------------------------
// timing: one memory cycle phase lasts at least this many ns
// ---------------------------------------------------------------
`define HRC_CLK_NS       40
`define HRC_PHASE_NS     70
`define HRC_PHASE_CYC    ((`HRC_PHASE_NS + `HRC_CLK_NS - 1) / `HRC_CLK_NS)
`define HRC_SCRATCH_RST  19'h00000
`define HRC_KEY_RST      64'h5A3C_96E1_0F7B_2D48

`endif

// *** pkg/hrc_pkg.sv ***
// types for the hidden clock access controller
package hrc_pkg;

    typedef enum logic [2:0] {
        HRC_IDLE,
        HRC_SETUP,
        HRC_STROBE,
        HRC_RECOVER,
        HRC_DONE
    } hrc_state_t;

    typedef enum logic [1:0] {
        HRC_PH_OPEN,
        HRC_PH_KEY,
        HRC_PH_XFER
    } hrc_phase_t;

endpackage

// *** testbench/hrc_dev_model.sv ***
// behavioural model of the memory with the hidden serial clock behind it
`timescale 1ns/1ps
`default_nettype none
`include "hrc_cfg.svh"
module hrc_dev_model
#(
    parameter logic [63:0] KEY = 64'hC3A5_1E2D_7B40_9F86 // arbitrary value
)
(
    // host pins
    input  wire logic        clk_i,
    input  wire logic        power_ok_i,
    input  wire logic        ce_n_i,
    input  wire logic        oe_n_i,
    input  wire logic        we_n_i,
    input  wire logic        abort_n_i,
    input  wire logic        sd_i,
    output logic             sd_o,
    // observation
    output logic      [63:0] img_o,
    output logic             xfer_o,
    output int               mem_wr_o
);
    logic        ce_q = 1'b1;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        d = 1'b0;
    logic        fail = 1'b0;
    logic        mem_bit = 1'b0;
    logic        last = 1'b0;
    logic        armed = 1'b0;
    logic        xfer = 1'b0;
    logic [63:0] img = 64'h0;
    int          wr_count = 0;
    logic [5:0]  ptr = 6'h00;
    logic [5:0]  idx = 6'h00;
    wire         drv = !ce_n_i && !oe_n_i && we_n_i && power_ok_i;
    wire         bitv = xfer ? img[idx] : mem_bit;
    // released line has no pull, so show the inverse of the last bit
    assign sd_o = drv ? bitv : ~last;
    assign img_o = img;
    assign xfer_o = xfer;
    assign mem_wr_o = wr_count;
    // img is never cleared by power loss: battery keeps it
    always @(posedge clk_i)
    begin
        ce_q <= ce_n_i;
        // backup is armed the first time supply is good
        if (power_ok_i)
            armed <= 1'b1;
        if (drv)
            last <= bitv;
        if (!ce_n_i)
        begin
            wr <= !we_n_i;
            rd <= !oe_n_i;
            d <= sd_i;
        end
        if (!abort_n_i && !img[`HRC_DAY_REG*8+`HRC_DAY_RST_BIT])
            xfer <= 1'b0;
        // only a release of this select closes a cycle; other devices' cycles pass by
        if (ce_n_i && !ce_q && power_ok_i)
        begin
            if (xfer)
            begin
                if (wr)
                    img[idx] <= d;
                idx <= idx + 6'h01;
                if (idx == 6'h3F)
                    xfer <= 1'b0;
            end
            else if (rd)
            begin
                ptr <= 6'h00;
                fail <= 1'b0;
            end
            else if (wr)
            begin
                mem_bit <= d;
                wr_count <= wr_count + 1;
                if (!fail && d == KEY[ptr])
                begin
                    ptr <= ptr + 6'h01;
                    xfer <= (ptr == 6'h3F);
                    idx <= 6'h00;
                end
                else
                    fail <= 1'b1;
            end
        end
    end
endmodule // hrc_dev_model
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the hidden clock access controller
`timescale 1ns/1ps
`default_nettype none
`include "hrc_cfg.svh"
`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin fail_count++; \
    $display("wrong value t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    localparam logic [63:0] KEY = 64'hC3A5_1E2D_7B40_9F86; // arbitrary value
    logic        clk_i, rstn_i, wr_i, rd_i, power_ok_i;
    logic [3:0]  addr_i;
    logic [31:0] wdata_i, rdata_o, s;
    logic [18:0] mem_addr_o;
    logic        ce_n, oe_n, we_n, sd_out, sd_oe_n, sd_dev, abort_n;
    logic [63:0] img, w, r, k;
    logic        xfer;
    int          mem_wr, m, n, cycles, fail_count, samples_checked;
    wire         sd_line = sd_oe_n ? sd_dev : sd_out;

    hrc_ctrl DUT (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .power_ok_i(power_ok_i),
        .mem_addr_o(mem_addr_o), .mem_ce_n_o(ce_n), .mem_oe_n_o(oe_n), .mem_we_n_o(we_n),
        .dq0_o(sd_out), .dq0_oe_n_o(sd_oe_n), .dq0_i(sd_line), .abort_n_o(abort_n));
    hrc_dev_model #(.KEY(KEY)) dev (.clk_i(clk_i), .power_ok_i(power_ok_i), .ce_n_i(ce_n),
        .oe_n_i(oe_n), .we_n_i(we_n), .abort_n_i(abort_n), .sd_i(sd_line), .sd_o(sd_dev),
        .img_o(img), .xfer_o(xfer), .mem_wr_o(mem_wr));

    initial
    begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    // -------------------------------------------------------------
    // command port tasks
    // -------------------------------------------------------------
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic reg_rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic run(input logic dir, input logic [63:0] key, input logic [63:0] wi,
                       output logic [63:0] ro);
        logic [31:0] st;
        int          p;
        reg_wr(`HRC_OFS_KEY_LO, key[31:0]);
        reg_wr(`HRC_OFS_KEY_HI, key[63:32]);
        reg_wr(`HRC_OFS_WDATA_LO, wi[31:0]);
        reg_wr(`HRC_OFS_WDATA_HI, wi[63:32]);
        reg_wr(`HRC_OFS_CTRL, {30'h0, dir, 1'b1});
        st = 32'h0;
        p = 0;
        while (st[31] !== 1'b1 && p < 400)
        begin
            reg_rd(`HRC_OFS_STATUS, st);
            p++;
        end
        `CHK(st[31], 1'b1)
        reg_rd(`HRC_OFS_RDATA_LO, ro[31:0]);
        reg_rd(`HRC_OFS_RDATA_HI, ro[63:32]);
    endtask
    // random image of BCD digits
    function automatic logic [63:0] bcd_img();
        logic [63:0] v;
        for (int i = 0; i < 16; i++)
            v[i*4 +: 4] = 4'($urandom % 10);
        // keep the oscillator running and the hours in 12-hour form
        v[`HRC_DAY_REG*8+`HRC_DAY_OSC_BIT] = 1'b0;
        v[`HRC_HOUR_REG*8+4 +: 4] = {1'b1, 1'b0, 1'($urandom), 1'b0};
        return v;
    endfunction
    task automatic test_done;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // hang guard: full run needs well under 10000 cycles
    always @(posedge clk_i)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            fail_count++;
            test_done();
        end
    end
    // -------------------------------------------------------------
    // main sequence
    // -------------------------------------------------------------
    initial
    begin
        {rstn_i, wr_i, rd_i, addr_i, wdata_i} = '0;
        power_ok_i = 1'b1;
        {cycles, fail_count, samples_checked} = '0;
        void'($urandom(32'h1584f514));
        repeat (4) @(posedge clk_i);
        rstn_i <= 1'b1;
        reg_rd(4'hF, s);
        `CHK(s, 32'h0)
        reg_rd(`HRC_OFS_SCRATCH, s);
        `CHK(s[18:0], `HRC_SCRATCH_RST)
        reg_wr(`HRC_OFS_SCRATCH, {13'h0, 19'($urandom)});
        repeat (2) @(posedge clk_i);
        `CHK(mem_addr_o, wdata_i[18:0])
        for (int i = 0; i < 3; i++)
        begin
            w = bcd_img();
            m = mem_wr;
            run(1'b1, KEY, w, r);
            `CHK(img, w)
            `CHK(mem_wr - m, 64)
            `CHK(xfer, 1'b0)
            run(1'b0, KEY, ~w, r);
            `CHK(r, w)
        end
        // one key bit wrong: image untouched, all writes land in memory
        k = KEY ^ (64'h1 << ($urandom % 64));
        m = mem_wr;
        run(1'b1, k, ~w, r);
        `CHK(img, w)
        `CHK(mem_wr - m, 128)
        // supply lost in mid key phase, then a go while down
        reg_wr(`HRC_OFS_CTRL, 32'h0000_0003);
        repeat (100) @(posedge clk_i);
        power_ok_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        `CHK(ce_n, 1'b1)
        reg_rd(`HRC_OFS_STATUS, s);
        `CHK(s[31], 1'b0)
        reg_wr(`HRC_OFS_CTRL, 32'h0000_0003);
        repeat (20) @(posedge clk_i);
        `CHK(ce_n, 1'b1)
        power_ok_i <= 1'b1;
        run(1'b0, KEY, w, r);
        `CHK(r, w)
        `CHK(dev.armed, 1'b1)
        // abort pin pulse on command: it stands for the one clock after the write
        reg_wr(`HRC_OFS_CTRL, 32'h0000_0004);
        #1 n = 0;
        while (abort_n !== 1'b0 && n < 4)
        begin
            @(posedge clk_i);
            #1 n++;
        end
        `CHK(abort_n, 1'b0)
        @(posedge clk_i);
        #1 `CHK(abort_n, 1'b1)
        test_done();
    end
endmodule // tb_top
`default_nettype wire
